// [rtl/cms_pkg.sv]
// constants and carrier types for the clock mode controller
// What this block does
// - stop exits on reset, nmi, peripheral interrupt
// - stop exit keeps source, main/oco divided 8
// - stop exit forces divide-by-8 select
// - peripheral wake runs its interrupt routine
// - pll only from/to high-speed, never stop
// - main oscillator off forces divide-by-8
// - divider codes give 1,2,4,16; div8 gives 8
// - source priority sub, oco, pll, main
// - control bits start/stop clocks, enter stop
// - monitor enable; action bit picks reset/irq
// - stop detection guaranteed at 2 MHz up
// - reset action halts until hardware reset
// - main source stop switches to oco, sets bits
// - pll source stop sets flags only
// - re-oscillation sets flag, clears stopped status
// - stop entry forces div8 and high drive
// - pending event flag masks further monitor irqs
// - low-speed main stop starts oco for peripherals
package cms_pkg;

    // control register image written and read by software
    typedef struct packed {
        logic       osc_fail_action;
        logic       osc_monitor_enable;
        logic       internal_osc_select;
        logic [1:0] cpu_div;
        logic       pll_source_select;
        logic       all_clock_stop;
        logic       main_drive_high;
        logic       sub_clock_select;
        logic       div8_select;
        logic       main_osc_off;
        logic       sub_osc_on;
    } cms_ctrl_t;

    typedef enum logic [1:0] {
        SRC_MAIN = 2'b00,
        SRC_PLL  = 2'b01,
        SRC_OCO  = 2'b10,
        SRC_SUB  = 2'b11
    } cms_src_t;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_HALT = 2'b10
    } cms_state_t;

    localparam cms_ctrl_t CTRL_RESET   = 12'h000;
    localparam logic [1:0] DIV_1       = 2'h0;
    localparam logic [4:0] RATIO_1     = 5'h01;
    localparam logic [4:0] RATIO_2     = 5'h02;
    localparam logic [4:0] RATIO_4     = 5'h04;
    localparam logic [4:0] RATIO_8     = 5'h08;
    localparam logic [4:0] RATIO_16    = 5'h10;
    localparam int        MIN_MAIN_KHZ = 2000;
    localparam int        SYNC_W       = 3;

endpackage

// [rtl/cms_clock_mode.sv]
// clock mode sequencer with stop exit and main oscillator monitor
`timescale 1ns/1ps
`default_nettype none
module cms_clock_mode
    import cms_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rstn_i,
    input  wire logic      sw_wr_i,
    input  wire cms_ctrl_t sw_ctrl_i,
    input  wire logic      sw_flag_clr_i,
    input  wire logic      main_alive_i,
    input  wire logic      nmi_i,
    input  wire logic      periph_wake_i,
    output logic           wr_refused_o,
    output cms_ctrl_t      ctrl_o,
    output logic           osc_event_flag_o,
    output logic           main_stopped_status_o,
    output cms_src_t       cpu_src_o,
    output logic [4:0]     cpu_ratio_o,
    output logic           cpu_clk_en_o,
    output logic           stop_mode_o,
    output logic           main_osc_run_o,
    output logic           sub_osc_run_o,
    output logic           oco_run_o,
    output logic           periph_on_oco_o,
    output logic           wake_irq_o,
    output logic           osc_irq_o,
    output logic           osc_reset_o
);

    ////////////////////////////////////////////////////////////////////
    // input synchronisers: alive, nmi, peripheral wake

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic              alive_prev_ff;
    logic              alive_s;
    logic              nmi_s;
    logic              pwake_s;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            sync1_ff      <= '0;
            sync2_ff      <= '0;
            alive_prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff      <= {periph_wake_i, nmi_i, main_alive_i};
            sync2_ff      <= sync1_ff;
            alive_prev_ff <= sync2_ff[0];
        end
    end

    assign alive_s = sync2_ff[0];
    assign nmi_s   = sync2_ff[1];
    assign pwake_s = sync2_ff[2];

    ////////////////////////////////////////////////////////////////////
    // decode and write legality

    cms_ctrl_t  ctl_ff;
    cms_state_t st_ff;
    logic       evt_flag_ff;
    logic       stopped_ff;
    logic       wake;
    logic       wr_ok;
    logic       ctl_hs;
    logic       new_hs;
    logic       mon_stop;
    logic       mon_reosc;
    logic       src_is_main;

    // high-speed: main or pll source, no division
    function automatic logic is_hs(input cms_ctrl_t c);
        is_hs = !c.internal_osc_select && !c.sub_clock_select
              && !c.div8_select && c.cpu_div == DIV_1;
    endfunction

    assign ctl_hs = is_hs(ctl_ff);
    assign new_hs = is_hs(sw_ctrl_i);
    // pll can only be reached from, or left into, high-speed mode
    assign wr_ok  = !(sw_ctrl_i.pll_source_select
                      || ctl_ff.pll_source_select)
                  || (new_hs && !sw_ctrl_i.all_clock_stop
                      && !sw_ctrl_i.main_osc_off
                      && (ctl_ff.pll_source_select || ctl_hs));
    assign wake   = nmi_s || pwake_s;

    // detection only meaningful for main clocks of MIN_MAIN_KHZ or more
    assign mon_stop  = ctl_ff.osc_monitor_enable
                     && alive_prev_ff && !alive_s;
    assign mon_reosc = ctl_ff.osc_monitor_enable
                     && !alive_prev_ff && alive_s;
    assign src_is_main = !ctl_ff.sub_clock_select
                       && !ctl_ff.internal_osc_select
                       && !ctl_ff.pll_source_select;

    ////////////////////////////////////////////////////////////////////
    // operating state

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_ff <= ST_RUN;
        else
        begin
            case (st_ff)
                ST_RUN:
                begin
                    if (mon_stop && !ctl_ff.osc_fail_action)
                        st_ff <= ST_HALT;
                    else if (sw_wr_i && wr_ok && sw_ctrl_i.all_clock_stop)
                        st_ff <= ST_STOP;
                end
                ST_STOP:
                begin
                    if (wake)
                        st_ff <= ST_RUN;
                end
                ST_HALT:
                    st_ff <= ST_HALT;
                default:
                    st_ff <= ST_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control bits

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctl_ff <= CTRL_RESET;
        else if (st_ff == ST_STOP)
        begin
            if (wake)
            begin
                // source bits kept, so main or oco comes back divided
                ctl_ff.all_clock_stop <= 1'b0;
                ctl_ff.div8_select    <= 1'b1;
            end
        end
        else if (st_ff == ST_RUN)
        begin
            if (sw_wr_i && wr_ok)
            begin
                ctl_ff <= sw_ctrl_i;
                if (sw_ctrl_i.main_osc_off)
                    ctl_ff.div8_select <= 1'b1;
                if (sw_ctrl_i.all_clock_stop)
                begin
                    ctl_ff.div8_select     <= 1'b1;
                    ctl_ff.main_drive_high <= 1'b1;
                end
            end
            if (mon_stop && ctl_ff.osc_fail_action && src_is_main)
                ctl_ff.internal_osc_select <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // monitor flags and interrupt

    logic oco_forced_ff;
    logic osc_irq_ff;
    logic irq_cond;

    assign irq_cond = (mon_stop || mon_reosc) && ctl_ff.osc_fail_action
                    && st_ff == ST_RUN;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            evt_flag_ff   <= 1'b0;
            stopped_ff    <= 1'b0;
            osc_irq_ff    <= 1'b0;
            oco_forced_ff <= 1'b0;
        end
        else
        begin
            osc_irq_ff <= irq_cond && !evt_flag_ff;
            if (irq_cond)
                evt_flag_ff <= 1'b1;
            else if (sw_flag_clr_i)
                evt_flag_ff <= 1'b0;
            if (mon_stop)
                stopped_ff <= 1'b1;
            else if (mon_reosc)
                stopped_ff <= 1'b0;
            if (irq_cond && mon_stop && !ctl_ff.pll_source_select)
                oco_forced_ff <= 1'b1;
            else if (sw_wr_i && wr_ok && !sw_ctrl_i.internal_osc_select
                     && !stopped_ff)
                oco_forced_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cpu clock source, divider and run outputs

    logic [4:0] ratio;
    logic [4:0] ratio_ff;
    logic [4:0] cnt_ff;
    cms_src_t   src;
    cms_src_t   src_ff;
    logic       wake_irq_ff;

    always_comb
    begin
        if (ctl_ff.div8_select)
            ratio = RATIO_8;
        else
        begin
            case (ctl_ff.cpu_div)
                2'h0:    ratio = RATIO_1;
                2'h1:    ratio = RATIO_2;
                2'h2:    ratio = RATIO_4;
                default: ratio = RATIO_16;
            endcase
        end
        if (ctl_ff.sub_clock_select)
            src = SRC_SUB;
        else if (ctl_ff.internal_osc_select)
            src = SRC_OCO;
        else if (ctl_ff.pll_source_select)
            src = SRC_PLL;
        else
            src = SRC_MAIN;
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ratio_ff <= RATIO_1;
            src_ff   <= SRC_MAIN;
            cnt_ff   <= 5'h00;
        end
        else
        begin
            ratio_ff <= ratio;
            src_ff   <= src;
            if (st_ff != ST_RUN || cnt_ff + 5'h01 >= ratio_ff)
                cnt_ff <= 5'h00;
            else
                cnt_ff <= cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            wake_irq_ff <= 1'b0;
        else
            wake_irq_ff <= st_ff == ST_STOP && pwake_s;
    end

    assign cpu_clk_en_o    = st_ff == ST_RUN && cnt_ff == 5'h00;
    assign wr_refused_o    = sw_wr_i && (st_ff != ST_RUN || !wr_ok);
    assign ctrl_o          = ctl_ff;
    assign osc_event_flag_o      = evt_flag_ff;
    assign main_stopped_status_o = stopped_ff;
    assign cpu_src_o       = src_ff;
    assign cpu_ratio_o     = ratio_ff;
    assign stop_mode_o     = st_ff == ST_STOP;
    assign main_osc_run_o  = st_ff == ST_RUN && !ctl_ff.main_osc_off;
    assign sub_osc_run_o   = st_ff == ST_RUN && ctl_ff.sub_osc_on;
    assign oco_run_o       = st_ff == ST_RUN
                           && (ctl_ff.internal_osc_select || oco_forced_ff);
    assign periph_on_oco_o = oco_run_o;
    assign wake_irq_o      = wake_irq_ff;
    assign osc_irq_o       = osc_irq_ff;
    assign osc_reset_o     = st_ff == ST_HALT;

    ////////////////////////////////////////////////////////////////////
    // checks

    stop_hold_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        st_ff == ST_STOP && !wake |=> st_ff == ST_STOP)
        else $error("stop left without wake");

    exit_src_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        st_ff == ST_STOP && wake |=> ##1
        src_ff == $past(src, 2) && st_ff == ST_RUN)
        else $error("clock source changed across stop");

    exit_div8_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        st_ff == ST_STOP && wake |=> ##1 ratio_ff == RATIO_8)
        else $error("stop exit not divided by 8");

    wake_irq_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        st_ff == ST_STOP && pwake_s |=> wake_irq_o && !stop_mode_o)
        else $error("peripheral wake missed");

    pll_hs_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        ctl_ff.pll_source_select |-> ctl_hs && st_ff != ST_STOP)
        else $error("pll outside high-speed mode");

    osc_off_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $rose(ctl_ff.main_osc_off) |-> ctl_ff.div8_select)
        else $error("main off without divide by 8");

    halt_hold_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        st_ff == ST_HALT |=> osc_reset_o [*3])
        else $error("halt released without reset");

    flag_mask_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        osc_irq_o |-> !$past(evt_flag_ff) && evt_flag_ff)
        else $error("monitor irq while flag pending");

    reosc_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        mon_reosc && ctl_ff.osc_fail_action && st_ff == ST_RUN
        |=> evt_flag_ff && !stopped_ff)
        else $error("re-oscillation status wrong");

endmodule
`default_nettype wire

// [sim/cms_osc_model.sv]
// main oscillator model: alive level follows a run command after start-up
`timescale 1ns/1ps
`default_nettype none
module cms_osc_model #(
    parameter int START_CYC = 4
) (
    input  wire logic clk_i,
    input  wire logic run_i,
    output logic      main_alive_o
);
    int cnt = 0;
    ////////////////////////////////////////////////////////////////////
    // loss of oscillation shows at once, a restart needs start-up time
    always @(posedge clk_i)
    begin
        if (!run_i)
        begin
            cnt <= 0;
            main_alive_o <= 1'b0;
        end
        else if (cnt < START_CYC)
            cnt <= cnt + 1;
        else
            main_alive_o <= 1'b1;
    end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the clock mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cms_pkg::*;
    typedef struct packed {
        logic [3:0] sel;
        logic [1:0] dv;
        cms_src_t   src;
        logic [4:0] r;
    } cms_row_t;
    logic clk_i = 1'b0, rstn_i = 1'b0, sw_wr_i = 1'b0, sw_flag_clr_i = 1'b0;
    logic nmi_i = 1'b0, periph_wake_i = 1'b0, run = 1'b1, main_alive;
    cms_ctrl_t sw_ctrl_i = CTRL_RESET, ctrl_o, c;
    logic wr_refused_o, osc_event_flag_o, main_stopped_status_o;
    logic cpu_clk_en_o, stop_mode_o, main_osc_run_o, sub_osc_run_o;
    logic oco_run_o, periph_on_oco_o, wake_irq_o, osc_irq_o, osc_reset_o;
    cms_src_t cpu_src_o;
    logic [4:0] cpu_ratio_o;
    int err_count = 0, checks = 0, cyc = 0, irq_cnt = 0, k, n;
    // sel = {sub select, internal select, pll select, div8 select}
    cms_row_t rows [13] = '{
        '{4'h0, 2'h0, SRC_MAIN, RATIO_1}, '{4'h0, 2'h1, SRC_MAIN, RATIO_2},
        '{4'h0, 2'h2, SRC_MAIN, RATIO_4}, '{4'h0, 2'h3, SRC_MAIN, RATIO_16},
        '{4'h1, 2'h0, SRC_MAIN, RATIO_8}, '{4'h4, 2'h0, SRC_OCO, RATIO_1},
        '{4'h4, 2'h3, SRC_OCO, RATIO_16}, '{4'h5, 2'h0, SRC_OCO, RATIO_8},
        '{4'h1, 2'h0, SRC_MAIN, RATIO_8}, '{4'h8, 2'h0, SRC_SUB, 5'h00},
        '{4'hc, 2'h0, SRC_SUB, 5'h00}, '{4'h0, 2'h0, SRC_MAIN, RATIO_1},
        '{4'h2, 2'h0, SRC_PLL, RATIO_1}};
    always #4 clk_i = ~clk_i;
    cms_osc_model OSC (.clk_i(clk_i), .run_i(run), .main_alive_o(main_alive));
    cms_clock_mode DUT (.clk_i(clk_i), .rstn_i(rstn_i), .sw_wr_i(sw_wr_i),
        .sw_ctrl_i(sw_ctrl_i), .sw_flag_clr_i(sw_flag_clr_i),
        .main_alive_i(main_alive), .nmi_i(nmi_i),
        .periph_wake_i(periph_wake_i), .wr_refused_o(wr_refused_o),
        .ctrl_o(ctrl_o), .osc_event_flag_o(osc_event_flag_o),
        .main_stopped_status_o(main_stopped_status_o),
        .cpu_src_o(cpu_src_o), .cpu_ratio_o(cpu_ratio_o),
        .cpu_clk_en_o(cpu_clk_en_o), .stop_mode_o(stop_mode_o),
        .main_osc_run_o(main_osc_run_o), .sub_osc_run_o(sub_osc_run_o),
        .oco_run_o(oco_run_o), .periph_on_oco_o(periph_on_oco_o),
        .wake_irq_o(wake_irq_o), .osc_irq_o(osc_irq_o),
        .osc_reset_o(osc_reset_o));
    ////////////////////////////////////////////////////////////////////
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (osc_irq_o === 1'b1)
            irq_cnt <= irq_cnt + 1;
        if (cyc == 2000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [11:0] e, g);
        checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    function automatic cms_ctrl_t mk(input logic [3:0] f, input logic [1:0] d);
        cms_ctrl_t t;
        t = CTRL_RESET;
        t.sub_osc_on = 1'b1;
        {t.sub_clock_select, t.internal_osc_select} = f[3:2];
        {t.pll_source_select, t.div8_select} = f[1:0];
        t.cpu_div = d;
        return t;
    endfunction
    // one write; refusal is looked at while the strobe is up
    task automatic wr(input cms_ctrl_t v, input logic ref_e);
        @(posedge clk_i);
        sw_wr_i <= 1'b1;
        sw_ctrl_i <= v;
        @(negedge clk_i);
        chk("refused", ref_e, wr_refused_o);
        @(posedge clk_i);
        sw_wr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic wake_wait();
        n = 0;
        while (stop_mode_o === 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk_i);
        @(negedge clk_i);
        chk("rst ctrl", CTRL_RESET, ctrl_o);
        chk("rst ratio", RATIO_1, cpu_ratio_o);
        @(posedge clk_i);
        rstn_i <= 1'b1;
        foreach (rows[i])
        begin
            wr(mk(rows[i].sel, rows[i].dv), 1'b0);
            chk("src", rows[i].src, cpu_src_o);
            if (rows[i].r != 5'h00)
                chk("ratio", rows[i].r, cpu_ratio_o);
        end
        $display("test modes done");
        c = mk(4'h2, 2'h0);
        c.all_clock_stop = 1'b1;
        wr(c, 1'b1);
        chk("pll kept", mk(4'h2, 2'h0), ctrl_o);
        wr(mk(4'h0, 2'h0), 1'b0);
        wr(mk(4'h0, 2'h1), 1'b0);
        wr(mk(4'h2, 2'h1), 1'b1);
        $display("test pll done");
        c = mk(4'h0, 2'h1);
        c.all_clock_stop = 1'b1;
        wr(c, 1'b0);
        chk("stop", 1'b1, stop_mode_o);
        chk("stop div8", 1'b1, ctrl_o.div8_select);
        chk("drive", 1'b1, ctrl_o.main_drive_high);
        chk("main run", 1'b0, main_osc_run_o);
        repeat (10) @(posedge clk_i);
        #1;
        chk("stays", 1'b1, stop_mode_o);
        @(posedge clk_i);
        nmi_i <= 1'b1;
        wake_wait();
        chk("nmi exit", 1'b0, stop_mode_o);
        chk("acs", 1'b0, ctrl_o.all_clock_stop);
        chk("exit div8", 1'b1, ctrl_o.div8_select);
        repeat (2) @(posedge clk_i);
        #1;
        chk("exit ratio", RATIO_8, cpu_ratio_o);
        chk("exit src", SRC_MAIN, cpu_src_o);
        n = 0;
        repeat (16)
        begin
            @(posedge clk_i);
            #1;
            n += cpu_clk_en_o;
        end
        chk("clk en", 2, n);
        nmi_i <= 1'b0;
        c = mk(4'h8, 2'h0);
        c.all_clock_stop = 1'b1;
        wr(c, 1'b0);
        @(posedge clk_i);
        periph_wake_i <= 1'b1;
        wake_wait();
        chk("wake irq", 1'b1, wake_irq_o);
        repeat (2) @(posedge clk_i);
        #1;
        chk("sub src", SRC_SUB, cpu_src_o);
        periph_wake_i <= 1'b0;
        $display("test stop done");
        c = mk(4'h8, 2'h0);
        c.main_osc_off = 1'b1;
        wr(c, 1'b0);
        chk("off div8", 1'b1, ctrl_o.div8_select);
        chk("main off", 1'b0, main_osc_run_o);
        chk("sub on", 1'b1, sub_osc_run_o);
        wr(mk(4'h1, 2'h0), 1'b0);
        c = mk(4'h0, 2'h0);
        c.osc_monitor_enable = 1'b1;
        c.osc_fail_action = 1'b1;
        wr(c, 1'b0);
        k = irq_cnt;
        run <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        chk("irq", 1, irq_cnt - k);
        chk("flag", 1'b1, osc_event_flag_o);
        chk("stopped", 1'b1, main_stopped_status_o);
        chk("int sel", 1'b1, ctrl_o.internal_osc_select);
        chk("oco", 1'b1, oco_run_o);
        chk("per oco", 1'b1, periph_on_oco_o);
        chk("oco src", SRC_OCO, cpu_src_o);
        run <= 1'b1;
        repeat (16) @(posedge clk_i);
        #1;
        chk("masked", 1, irq_cnt - k);
        chk("reosc", 1'b0, main_stopped_status_o);
        chk("int kept", 1'b1, ctrl_o.internal_osc_select);
        @(posedge clk_i);
        sw_flag_clr_i <= 1'b1;
        @(posedge clk_i);
        sw_flag_clr_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("flag clr", 1'b0, osc_event_flag_o);
        run <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        chk("irq again", 2, irq_cnt - k);
        run <= 1'b1;
        repeat (16) @(posedge clk_i);
        sw_flag_clr_i <= 1'b1;
        @(posedge clk_i);
        sw_flag_clr_i <= 1'b0;
        c = mk(4'h8, 2'h0);
        c.osc_monitor_enable = 1'b1;
        c.osc_fail_action = 1'b1;
        wr(c, 1'b0);
        run <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        chk("ls irq", 3, irq_cnt - k);
        chk("ls per oco", 1'b1, periph_on_oco_o);
        chk("ls src", SRC_SUB, cpu_src_o);
        run <= 1'b1;
        repeat (16) @(posedge clk_i);
        $display("test monitor done");
        c.osc_fail_action = 1'b0;
        c.internal_osc_select = 1'b0;
        wr(c, 1'b0);
        run <= 1'b0;
        repeat (12) @(posedge clk_i);
        #1;
        chk("halt", 1'b1, osc_reset_o);
        repeat (30) @(posedge clk_i);
        #1;
        chk("halt held", 1'b1, osc_reset_o);
        wr(mk(4'h0, 2'h0), 1'b1);
        run <= 1'b1;
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("halt left", 1'b0, osc_reset_o);
        rstn_i <= 1'b1;
        $display("test halt done");
        report_and_stop();
    end
endmodule
`default_nettype wire
